/* File: design/kpl_latch.sv */
// keypad interrupt latch with AHB-Lite register slave and port A pad control
`timescale 1ns/100ps
module kpl_latch (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  input  wire logic [7:0]           pin_in,
  output kpl_pkg::kpl_pad_type      pad,
  input  wire logic                 vec_fetch,
  input  wire logic [15:0]          vec_addr,
  input  wire logic                 brk_state,
  input  wire logic                 brk_clear_en,
  output logic                      keypad_irq
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // input six is only a keypad input with the rc option and its port enable
  function automatic logic [7:0] eff_en(input logic [7:0] en, input logic p6, input logic osc);
    logic [7:0] e;
    e = en;
    e[kpl_pkg::PIN_SIX] = en[kpl_pkg::PIN_SIX] & p6 & ~osc;
    return e;
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  kpl_pkg::kpl_bus_state_type state_r;
  kpl_pkg::kpl_bus_state_type state_nxt;
  kpl_pkg::kpl_pad_type       pad_r;
  logic [7:0]                 addr_r;
  logic [31:0]                hrdata_r;
  logic                       hready_r;
  logic [7:0]                 sync1_r;
  logic [7:0]                 sync2_r;
  logic                       prev_low_r;
  logic                       latch_r;
  logic                       keypad_pending_flag_r;
  logic                       irq_r;
  logic                       mask_r;
  logic                       sens_r;
  logic [7:0]                 en_r;
  logic [7:0]                 dir_r;
  logic [7:0]                 pu_r;
  logic [7:0]                 data_r;
  logic                       p6en_r;
  logic                       osc_r;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        addr_take = hsel & hready & htrans[1];
  wire        wr_go     = state_r == kpl_pkg::BUS_WRITE;
  wire        wr_scr    = wr_go & hit(addr_r, kpl_pkg::OFF_SCR);
  wire        wr_enr    = wr_go & hit(addr_r, kpl_pkg::OFF_ENR);
  wire        wr_cfg    = wr_go & hit(addr_r, kpl_pkg::OFF_CFG);
  wire        wr_dat    = wr_go & hit(addr_r, kpl_pkg::OFF_DAT);

  // ----------------------------------------------------------------
  // detection and acknowledge
  // ----------------------------------------------------------------
  // disabled pins count as high, so they never block or raise a request
  wire [7:0]  en_eff    = eff_en(en_r, p6en_r, osc_r);
  wire        any_low   = |(~sync2_r & en_eff);
  wire        edge_set  = any_low & ~prev_low_r;
  // break state protects the latch from acknowledge writes unless clearing is allowed
  wire        brk_lock  = brk_state & ~brk_clear_en;
  wire        ack_sw    = wr_scr & hwdata[kpl_pkg::SCR_ACK] & ~brk_lock;
  wire        ack_vec   = vec_fetch & (vec_addr[15:1] == kpl_pkg::VEC_KEYPAD[15:1]);
  wire        ack       = ack_sw | ack_vec;
  // set wins over a same-cycle acknowledge, so no edge is lost
  wire        latch_nxt = edge_set | (latch_r & ~ack);
  // level mode holds the request while a pin is low, even after ack
  wire        pend_nxt  = latch_nxt | (sens_r & any_low);
  wire        mask_nxt  = wr_scr ? hwdata[kpl_pkg::SCR_MASK] : mask_r;
  wire        sens_nxt  = wr_scr ? hwdata[kpl_pkg::SCR_SENS] : sens_r;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // a pin reads its level only while its direction bit is 0
  wire [7:0]  dat_rd    = (dir_r & data_r) | (~dir_r & sync2_r);
  wire [31:0] scr_rd    = {28'h0000000, keypad_pending_flag_r, 1'b0, mask_r, sens_r};
  wire [31:0] cfg_rd    = {14'h0000, osc_r, p6en_r, pu_r, dir_r};
  wire [31:0] rd_mux    = hit(addr_r, kpl_pkg::OFF_SCR) ? scr_rd :
                          hit(addr_r, kpl_pkg::OFF_ENR) ? {24'h000000, en_r} :
                          hit(addr_r, kpl_pkg::OFF_CFG) ? cfg_rd :
                          hit(addr_r, kpl_pkg::OFF_DAT) ? {24'h000000, dat_rd} : 32'h00000000;

  // next bus state; reads take one wait state so a write just before is seen
  always_comb begin
    state_nxt = kpl_pkg::BUS_IDLE;
    case (state_r)
      kpl_pkg::BUS_READ: state_nxt = kpl_pkg::BUS_IDLE;
      kpl_pkg::BUS_IDLE,
      kpl_pkg::BUS_WRITE: begin
        if (addr_take) begin
          state_nxt = hwrite ? kpl_pkg::BUS_WRITE : kpl_pkg::BUS_READ;
        end
      end
      default: state_nxt = kpl_pkg::BUS_IDLE;
    endcase
  end

  // bus slave state and read data
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r  <= kpl_pkg::BUS_IDLE;
      addr_r   <= 8'h00;
      hready_r <= 1'b1;
      hrdata_r <= 32'h00000000;
    end else begin
      state_r  <= state_nxt;
      addr_r   <= addr_take ? haddr[7:0] : addr_r;
      hready_r <= ~(addr_take & ~hwrite);
      hrdata_r <= (state_r == kpl_pkg::BUS_READ) ? rd_mux : hrdata_r;
    end
  end

  // control registers; writes land in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_r <= 1'b0;
      sens_r <= 1'b0;
      en_r   <= kpl_pkg::RST_BYTE;
      dir_r  <= kpl_pkg::RST_BYTE;
      pu_r   <= kpl_pkg::RST_BYTE;
      data_r <= kpl_pkg::RST_BYTE;
      p6en_r <= 1'b0;
      osc_r  <= kpl_pkg::RST_OSC;
    end else begin
      mask_r <= mask_nxt;
      sens_r <= sens_nxt;
      en_r   <= wr_enr ? hwdata[7:0] : en_r;
      dir_r  <= wr_cfg ? hwdata[kpl_pkg::CFG_DIR +: 8] : dir_r;
      pu_r   <= wr_cfg ? hwdata[kpl_pkg::CFG_PU +: 8] : pu_r;
      p6en_r <= wr_cfg ? hwdata[kpl_pkg::CFG_P6EN] : p6en_r;
      osc_r  <= wr_cfg ? hwdata[kpl_pkg::CFG_OSC] : osc_r;
      data_r <= wr_dat ? hwdata[7:0] : data_r;
    end
  end

  // two-stage pin synchroniser; only sync2_r feeds detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 8'hff;
      sync2_r <= 8'hff;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
    end
  end

  // latch and flag; no clock gating, so wait and stop do not stop it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_low_r <= 1'b0;
      latch_r    <= 1'b0;
      keypad_pending_flag_r     <= 1'b0;
      irq_r      <= 1'b0;
    end else begin
      prev_low_r <= any_low;
      latch_r    <= latch_nxt;
      keypad_pending_flag_r     <= pend_nxt;
      irq_r      <= pend_nxt & ~mask_nxt;
    end
  end

  // pad drive: enabled pins become inputs with pull-up on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad_r <= '0;
    end else begin
      pad_r.dout <= data_r;
      pad_r.oe   <= dir_r & ~en_eff;
      pad_r.pull <= pu_r | en_eff;
    end
  end

  assign hreadyout  = hready_r;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_r;
  assign pad        = pad_r;
  assign keypad_irq = irq_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_scr_read;
    state_r == kpl_pkg::BUS_READ && hit(addr_r, kpl_pkg::OFF_SCR);
  endsequence

  sequence s_read_addr;
    addr_take && !hwrite;
  endsequence

  AST_EDGE_SETS: assert property (edge_set |=> keypad_pending_flag_r)
    else $error("falling edge did not latch a request");
  AST_EDGE_BLOCK: assert property (prev_low_r && !latch_r && !sens_r |=> !keypad_pending_flag_r)
    else $error("request latched while a pin was already low");
  AST_LEVEL_HOLD: assert property (sens_r && any_low |=> keypad_pending_flag_r)
    else $error("level request dropped while pin low");
  // a mode switch in the ack cycle legally lets a held pin go, so it is excused
  AST_LEVEL_ACK: assert property (sens_r && ack && any_low |=> keypad_pending_flag_r ##1
                                  (keypad_pending_flag_r || !$past(any_low) || !$past(sens_r)))
    else $error("level request cleared while pin low");
  AST_EDGE_ACK: assert property (!sens_r && ack && !edge_set |=> !keypad_pending_flag_r)
    else $error("edge request survived acknowledge");
  AST_ACK_EDGE: assert property (ack_sw && edge_set |=> keypad_pending_flag_r)
    else $error("edge lost in acknowledge cycle");
  AST_VEC_ONLY: assert property (latch_r && !edge_set && !ack_sw && !ack_vec |=> latch_r)
    else $error("latch cleared without keypad acknowledge");
  AST_BRK_PROTECT: assert property (latch_r && brk_lock && !ack_vec |=> latch_r)
    else $error("acknowledge write cleared latch in break");
  // an unmask write or a vector fetch may legally change flag or irq next cycle
  AST_MASK_POLL: assert property (latch_r && mask_r && !wr_scr && !ack_vec |=> keypad_pending_flag_r && !irq_r)
    else $error("flag or irq wrong while masked");
  AST_IRQ_OUT: assert property (keypad_pending_flag_r && !mask_r && !wr_scr |=> !keypad_pending_flag_r || irq_r)
    else $error("unmasked request not presented");
  AST_PULL: assert property (1'b1 |=> (pad_r.pull & $past(en_eff)) == $past(en_eff))
    else $error("enabled pin lacks pull-up");
  AST_INPUT_FORCE: assert property (1'b1 |=> (pad_r.oe & $past(en_eff)) == 8'h00)
    else $error("enabled pin driven as output");
  AST_ACK_READ0: assert property (s_scr_read |=> !hrdata_r[kpl_pkg::SCR_ACK] &&
                                  hrdata_r[kpl_pkg::SCR_FLAG] == $past(keypad_pending_flag_r))
    else $error("status read wrong");
  AST_PIN_SIX: assert property (osc_r |-> !en_eff[kpl_pkg::PIN_SIX])
    else $error("input six active without rc option");
  AST_RESET: assert property ($rose(hresetn) |-> !keypad_pending_flag_r && !sens_r && !irq_r)
    else $error("reset did not clear request");
  AST_READ_WAIT: assert property (s_read_addr |=> !hready_r ##1 hready_r)
    else $error("read wait state wrong");

endmodule

/* File: design/kpl_pkg.sv */
// constants, types and field layout for the keypad interrupt latch
// Functional notes
// - eight port pins act as interrupt inputs, each enabled alone, one common mask.
// - an enabled keypad pin also gets its pull-up, whatever the port pull-up bits say.
// - a request latches when an enabled pin goes low after all were high.
// - edge mode ignores a falling edge while another enabled pin is already low.
// - edge-plus-level mode keeps the request while any enabled pin stays low.
// - level mode clears only after acknowledge and all pins high, either order.
// - fetching the keypad vector acknowledges and clears the request.
// - software writing 1 to the acknowledge bit does the same as a fetch.
// - a falling edge after a software acknowledge latches a fresh request.
// - with the mask clear a latched request goes to the cpu, vector ffe0/ffe1.
// - edge mode clears at once on acknowledge, regardless of pin levels.
// - reset clears request and sensitivity bit even with a pin held low.
// - the pending flag shows the request regardless of the mask.
// - an enabled pin is forced to input; pin read only while direction is 0.
// - input six works only with rc oscillator option and pin-6 port enable set.
// - acknowledge bit reads 0; flag, mask, sensitivity and enables reset to 0.
// - in break state without break-clear-enable an acknowledge write does nothing.
// - logic stays active in wait and stop; unmasked request wakes the mcu.
package kpl_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, low address byte decoded)
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_SCR     = 8'h00;  // keypad_status_control_register
  localparam logic [7:0]  OFF_ENR     = 8'h04;  // keypad_enable_register
  localparam logic [7:0]  OFF_CFG     = 8'h08;  // port direction, pull-up, pin-6 options
  localparam logic [7:0]  OFF_DAT     = 8'h0c;  // port data latch / pin read

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          SCR_FLAG    = 3;      // keypad_pending_flag, read only
  localparam int          SCR_ACK     = 2;      // keypad_ack_bit, write only
  localparam int          SCR_MASK    = 1;      // keypad_mask_bit
  localparam int          SCR_SENS    = 0;      // keypad_sensitivity_select
  localparam int          CFG_DIR     = 0;      // port_direction_register, 8 bits
  localparam int          CFG_PU      = 8;      // port_pullup_enable_bit x8
  localparam int          CFG_P6EN    = 16;     // pin6_port_enable
  localparam int          CFG_OSC     = 17;     // oscillator_option_select, 0 = rc
  localparam int          PIN_SIX     = 6;

  // ----------------------------------------------------------------
  // reset values and vector
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic        RST_OSC     = 1'b1;
  localparam logic [15:0] VEC_KEYPAD  = 16'hffe0;  // vector pair ffe0/ffe1

  typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ} kpl_bus_state_type;

  // pad-side outputs of port A travel together
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
    logic [7:0] pull;
  } kpl_pad_type;

endpackage

/* File: sim/kpl_keys.sv */
// key switch model standing on the port A pins
`timescale 1ns/100ps
module kpl_keys (
  input  wire logic                 hclk,
  input  wire logic [7:0]           press,
  input  wire kpl_pkg::kpl_pad_type pad,
  output logic [7:0]                pin_in
);
  logic [7:0] float_r = 8'h5a;

  // ----------------------------------------------------------------
  // pin levels
  // ----------------------------------------------------------------
  // a floating pin wanders so a stale level is never trusted
  always @(posedge hclk) float_r <= ~float_r;

  // a closed key shorts the pin to ground and beats every driver
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (press[i]) pin_in[i] = 1'b0;
      else if (pad.oe[i]) pin_in[i] = pad.dout[i];
      else if (pad.pull[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_r[i];
    end
  end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the keypad interrupt latch
`timescale 1ns/100ps
module testbench;
  logic                 hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0]          haddr, hwdata, hrdata, rd, seed;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [7:0]           pin_in, press;
  logic [15:0]          vec_addr;
  logic                 vec_fetch, brk_state, brk_clear_en, keypad_irq, m_mask, m_sens;
  kpl_pkg::kpl_pad_type pad;
  int                   failures, checks_done;

  // ----------------------------------------------------------------
  // clock, design and key model
  // ----------------------------------------------------------------
  initial hclk = 1'b0;
  always #2 hclk = ~hclk;
  assign hready = hreadyout;  // one slave, so its ready is the bus ready

  kpl_latch kpl_latch_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pin_in(pin_in), .pad(pad), .vec_fetch(vec_fetch), .vec_addr(vec_addr),
    .brk_state(brk_state), .brk_clear_en(brk_clear_en), .keypad_irq(keypad_irq));
  kpl_keys kpl_keys_inst (.hclk(hclk), .press(press), .pad(pad), .pin_in(pin_in));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // single transfer; every phase held until ready is sampled high
  // no cycle count is assumed: only the watchdog ends a wait
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  // model keeps mask and sensitivity as software last wrote them
  task automatic wscr(input logic [31:0] v);
    m_mask = v[1];
    m_sens = v[0];
    bus(1'b1, kpl_pkg::OFF_SCR, v);
  endtask

  // flag and cpu request compared with the model
  task automatic cscr(input logic flag);
    bus(1'b0, kpl_pkg::OFF_SCR, 32'h0);
    chk(rd, {28'h0000000, flag, 1'b0, m_mask, m_sens});
    chk({31'h0, keypad_irq}, {31'h0, flag & ~m_mask});
  endtask

  // two sync stages plus the latch, one edge spare
  task automatic settle;
    repeat (4) @(posedge hclk);
  endtask

  task automatic vfetch(input logic [15:0] a);
    vec_fetch <= 1'b1;
    vec_addr  <= a;
    @(posedge hclk);
    vec_fetch <= 1'b0;
    @(posedge hclk);
  endtask

  task automatic conclude;
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, far beyond the two hundred or so cycles the run needs
  initial begin
    repeat (3000) @(posedge hclk);
    failures++;
    conclude();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {hsel, hwrite, vec_fetch, brk_state, brk_clear_en, m_mask, m_sens} = 7'h00;
    {haddr, hwdata, htrans, hsize, press, vec_addr} = {64'h0, 2'h0, 3'h2, 8'h00, 16'h0000};
    {failures, checks_done} = {32'sd0, 32'sd0};
    seed = 32'h0001419a;
    hresetn = 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    cscr(1'b0);
    bus(1'b0, kpl_pkg::OFF_ENR, 32'h0); chk(rd, 32'h0);
    bus(1'b0, kpl_pkg::OFF_CFG, 32'h0); chk(rd, 32'h00020000);
    bus(1'b0, 8'h10, 32'h0); chk(rd, 32'h0);
    // pins first held high as outputs, then the masked start-up
    bus(1'b1, kpl_pkg::OFF_DAT, 32'hff);
    bus(1'b1, kpl_pkg::OFF_CFG, 32'h000200ff);
    wscr(32'h2);
    bus(1'b1, kpl_pkg::OFF_ENR, 32'h03);
    wscr(32'h6);
    wscr(32'h0);
    cscr(1'b0);
    chk({24'h0, pad.oe}, 32'hfc);
    chk({24'h0, pad.pull}, 32'h03);
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      bus(1'b1, kpl_pkg::OFF_DAT, {24'h0, seed[7:0]});
      bus(1'b0, kpl_pkg::OFF_DAT, 32'h0); chk(rd, {24'h0, seed[7:0]});
      chk({24'h0, pad.dout}, {24'h0, seed[7:0]});
    end
    // edge-only sensitivity
    press <= 8'h01; settle(); cscr(1'b1);
    wscr(32'h4); cscr(1'b0);
    press <= 8'h03; settle(); cscr(1'b0);
    press <= 8'h00; settle(); press <= 8'h02; settle(); cscr(1'b1);
    vfetch(16'hfffa); cscr(1'b1);
    vfetch(kpl_pkg::VEC_KEYPAD); cscr(1'b0);
    // edge reaches detection in the very cycle of the ack write: set wins
    press <= 8'h00; settle(); press <= 8'h01; @(posedge hclk);
    wscr(32'h4); cscr(1'b1);
    press <= 8'h00; settle(); press <= 8'h01; settle();
    brk_state <= 1'b1; wscr(32'h4); cscr(1'b1);
    brk_clear_en <= 1'b1; wscr(32'h4); cscr(1'b0);
    {brk_state, brk_clear_en} <= 2'h0;
    press <= 8'h00; settle(); wscr(32'h2);
    press <= 8'h01; settle(); cscr(1'b1);
    // edge plus level sensitivity, both orders of ack and release
    wscr(32'h1); cscr(1'b1);
    wscr(32'h5); cscr(1'b1);
    press <= 8'h00; settle(); cscr(1'b0);
    press <= 8'h01; settle(); press <= 8'h00; settle(); cscr(1'b1);
    wscr(32'h5); cscr(1'b0);
    // input six needs the rc option and its port enable
    bus(1'b1, kpl_pkg::OFF_ENR, 32'h40);
    press <= 8'h40; settle(); cscr(1'b0);
    bus(1'b1, kpl_pkg::OFF_CFG, 32'h000100ff); settle(); cscr(1'b1);
    // reset in mid-run with the key still held down
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    {m_mask, m_sens} = 2'h0;
    @(posedge hclk);
    cscr(1'b0);
    bus(1'b0, kpl_pkg::OFF_ENR, 32'h0); chk(rd, 32'h0);
    conclude();
  end
endmodule
